// ===== verilog/pmi_pkg.sv
// Shared constants, types and register map of the mode and interrupt control block
package pmi_pkg;

    // Register offsets, as seen over the two-wire host port
    localparam logic [7:0] PMI_ADDR_SUPPLY_STATUS = 8'h02;
    localparam logic [7:0] PMI_ADDR_IRQ_MASK_A = 8'h03;
    localparam logic [7:0] PMI_ADDR_IRQ_MASK_B = 8'h04;
    localparam logic [7:0] PMI_ADDR_IRQ_CAUSE_A = 8'h05;
    localparam logic [7:0] PMI_ADDR_IRQ_CAUSE_B = 8'h06;
    localparam logic [7:0] PMI_ADDR_FAULT_MASK = 8'h07;
    localparam logic [7:0] PMI_ADDR_MODE_CTRL = 8'h08;

    // Mode control field positions
    localparam int PMI_MODE_STANDBY_BIT = 7;
    localparam int PMI_MODE_SLEEP_BIT = 6;
    localparam int PMI_MODE_LFOSC_BIT = 3;
    localparam int PMI_MODE_DFLT_N_BIT = 1;
    localparam int PMI_MODE_SOFTRST_BIT = 0;
    // Bits that exist in mode control; the others read as zero
    localparam logic [7:0] PMI_MODE_CTRL_USED = 8'hCB;

    // Second cause group field positions
    localparam int PMI_CB_ADC_BIT = 7;
    localparam int PMI_CB_ANLG1_BIT = 6;
    localparam int PMI_CB_GPIO2_BIT = 5;
    localparam int PMI_CB_GPIO1_BIT = 4;
    localparam int PMI_CB_THERM_BIT = 3;
    localparam int PMI_CB_CHG_BIT = 2;
    localparam int PMI_CB_ADC_HI_BIT = 1;
    localparam int PMI_CB_ADC_LO_BIT = 0;

    // Power-up values
    localparam logic [7:0] PMI_FAULT_MASK_RST = 8'hFF;
    localparam logic [7:0] PMI_IRQ_MASK_RST = 8'hFF;
    localparam logic [7:0] PMI_MODE_CTRL_RST = 8'h00;
    localparam logic [7:0] PMI_CAUSE_RST = 8'h00;

    // Default slave address on the host port
    localparam logic [6:0] PMI_I2C_DEV_ADDR = 7'h48;

    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [7:0] data;
    } pmi_wr_s;

    typedef struct packed {
        logic ext_supply;
        logic charger;
        logic battery;
        logic thermal;
        logic adc_done;
        logic anlg1_open;
        logic adc_hi;
        logic adc_lo;
    } pmi_misc_s;

    typedef enum logic [3:0] {
        PMI_I2C_IDLE,
        PMI_I2C_ADDR,
        PMI_I2C_ADDR_ACK,
        PMI_I2C_REG,
        PMI_I2C_REG_ACK,
        PMI_I2C_WDATA,
        PMI_I2C_WDATA_ACK,
        PMI_I2C_RDATA,
        PMI_I2C_RDATA_ACK
    } pmi_i2c_state_e;

endpackage

// ===== verilog/pmi_i2c_slave.sv
// Two-wire register port slave with auto-incrementing register pointer
`timescale 1ns/1ps
module pmi_i2c_slave import pmi_pkg::*; #(
    parameter logic [6:0] DEV_ADDR = PMI_I2C_DEV_ADDR
) (
    input wire logic clock,            // System clock
    input wire logic rst,              // Async reset, active high
    input wire logic run,              // Low holds the engine idle
    input wire logic scl,              // Serial clock level
    input wire logic sda_in,           // Serial data level
    output logic sda_oe,               // High pulls the data line low
    output logic [7:0] rd_addr,        // Register pointer for reads
    input wire logic [7:0] rd_data,    // Read value at rd_addr
    output pmi_wr_s wr                 // One-cycle register write
);
    pmi_i2c_state_e state_q;
    logic scl_q, sda_q, done_q, nack_q;
    logic [2:0] cnt_q;
    logic [7:0] sh_q, ptr_q;
    logic start, stop, rise, fall;

    assign start = scl_q & scl & sda_q & ~sda_in;
    assign stop = scl_q & scl & ~sda_q & sda_in;
    assign rise = ~scl_q & scl;
    assign fall = scl_q & ~scl;
    assign rd_addr = ptr_q;

    always_comb begin
        unique case (state_q)
            PMI_I2C_ADDR_ACK, PMI_I2C_REG_ACK, PMI_I2C_WDATA_ACK: sda_oe = 1'b1;
            PMI_I2C_RDATA: sda_oe = ~sh_q[7];
            default: sda_oe = 1'b0;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl;
            sda_q <= sda_in;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= PMI_I2C_IDLE;
            cnt_q <= 3'h0;
            sh_q <= 8'h00;
            ptr_q <= 8'h00;
            done_q <= 1'b0;
            nack_q <= 1'b0;
            wr <= '0;
        end else begin
            wr.valid <= 1'b0;
            if (!run || stop) begin
                state_q <= PMI_I2C_IDLE;
            end else if (start) begin
                state_q <= PMI_I2C_ADDR;
                cnt_q <= 3'h0;
                done_q <= 1'b0;
            end else begin
                unique case (state_q)
                    PMI_I2C_IDLE: ;
                    PMI_I2C_ADDR, PMI_I2C_REG, PMI_I2C_WDATA: begin
                        if (rise) begin
                            sh_q <= {sh_q[6:0], sda_in};
                            cnt_q <= cnt_q + 3'h1;
                            done_q <= (cnt_q == 3'h7);
                        end else if (fall && done_q) begin
                            done_q <= 1'b0;
                            if (state_q == PMI_I2C_ADDR) begin
                                state_q <= (sh_q[7:1] == DEV_ADDR) ? PMI_I2C_ADDR_ACK
                                                                  : PMI_I2C_IDLE;
                            end else if (state_q == PMI_I2C_REG) begin
                                state_q <= PMI_I2C_REG_ACK;
                                ptr_q <= sh_q;
                            end else begin
                                state_q <= PMI_I2C_WDATA_ACK;
                                wr.valid <= 1'b1;
                                wr.addr <= ptr_q;
                                wr.data <= sh_q;
                                ptr_q <= ptr_q + 8'h01;
                            end
                        end
                    end
                    PMI_I2C_ADDR_ACK: begin
                        if (fall) begin
                            if (sh_q[0]) begin
                                state_q <= PMI_I2C_RDATA;
                                sh_q <= rd_data;
                                ptr_q <= ptr_q + 8'h01;
                            end else begin
                                state_q <= PMI_I2C_REG;
                            end
                        end
                    end
                    PMI_I2C_REG_ACK, PMI_I2C_WDATA_ACK: begin
                        if (fall) begin
                            state_q <= PMI_I2C_WDATA;
                        end
                    end
                    PMI_I2C_RDATA: begin
                        if (fall) begin
                            sh_q <= {sh_q[6:0], 1'b1};
                            cnt_q <= cnt_q + 3'h1;
                            if (cnt_q == 3'h7) begin
                                state_q <= PMI_I2C_RDATA_ACK;
                            end
                        end
                    end
                    PMI_I2C_RDATA_ACK: begin
                        if (rise) begin
                            nack_q <= sda_in;
                        end else if (fall) begin
                            if (nack_q) begin
                                state_q <= PMI_I2C_IDLE;
                            end else begin
                                state_q <= PMI_I2C_RDATA;
                                sh_q <= rd_data;
                                ptr_q <= ptr_q + 8'h01;
                            end
                        end
                    end
                endcase
            end
        end
    end

endmodule // pmi_i2c_slave

// ===== verilog/pmi_mode_irq_ctrl.sv
// Mode requests, supply fault masking and latched interrupt controller
//
// Summary of operation
// - Defaults reload clears the defaults-loaded flag.
// - Supply status register, bit set means fault.
// - Fault mask bit one excludes that supply.
// - Unmasked supply status change signals fault event.
// - Monitor supply, charger, battery, thermal, converter sources.
// - Input-configured general pins interrupt on edges.
// - Interrupt masks block masked sources entirely.
// - Set cause bits first, then pull line low.
// - While line low, causes frozen, changes ignored.
// - Host writes zero to cause, line releases.
// - Abandoned host transfer keeps line low.
// - Supply faults raised regardless of interrupt line.
// - Ignore sources, release line during system reset.
// - Fault mask powers up fully masked.
// - Hardware or software reset keeps register contents.
`timescale 1ns/1ps
module pmi_mode_irq_ctrl import pmi_pkg::*; #(
    parameter logic [6:0] DEV_ADDR = PMI_I2C_DEV_ADDR
) (
    input wire logic clock,                   // System clock, 125 MHz
    input wire logic rst,                     // Power-on reset, async, active high
    input wire logic system_reset_out_n,      // System reset output level, low in reset
    input wire logic scl,                     // Host serial clock
    input wire logic sda_in,                  // Host serial data, line level
    output logic sda_out,                     // Serial data drive value
    output logic sda_oe,                      // Serial data pull-low enable
    output logic irq_n_out,                   // Interrupt line drive value
    output logic irq_n_oe,                    // Interrupt line pull-low enable
    input wire logic [7:0] supply_fault,      // Per-supply out-of-regulation levels
    input wire pmi_misc_s misc_status,        // Other monitored status levels
    input wire logic [1:0] gpio_in,           // General pin levels
    input wire logic [1:0] gpio_is_input,     // General pin configured as input
    output logic soft_reset_req,              // Reset mode request pulse
    output logic sleep_req,                   // Sleep mode request pulse
    output logic buck_standby_request,        // Both bucks to standby
    output logic led_boost_low_freq_osc,      // LED boost oscillator select
    output logic supply_fault_evt             // Supply fault event pulse
);

    function automatic logic [7:0] toggled(input logic [7:0] now, input logic [7:0] was);
        toggled = now ^ was;
    endfunction

    pmi_wr_s wr;
    logic [7:0] rd_addr, rd_data;
    logic [7:0] status_q, status_prev_q;
    logic [7:0] fault_mask_q, irq_mask_a_q, irq_mask_b_q;
    logic [7:0] cause_a_q, cause_b_q;
    logic [7:0] mode_q;
    logic [7:0] misc_now, misc_prev_q;
    logic [1:0] gpio_prev_q;
    logic [7:0] chg_a, chg_b, hit_a, hit_b;
    logic fault_evt, irq_low_q, irq_idle;
    logic wr_mode, wr_fault_mask;

    pmi_i2c_slave #(
        .DEV_ADDR(DEV_ADDR)
    ) u_host_port (
        .clock(clock),
        .rst(rst),
        .run(system_reset_out_n),
        .scl(scl),
        .sda_in(sda_in),
        .sda_oe(sda_oe),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .wr(wr)
    );

    assign sda_out = 1'b0;
    assign wr_mode = wr.valid && (wr.addr == PMI_ADDR_MODE_CTRL);
    assign wr_fault_mask = wr.valid && (wr.addr == PMI_ADDR_FAULT_MASK);

    // Unmapped offsets read as zero
    always_comb begin
        unique case (rd_addr)
            PMI_ADDR_SUPPLY_STATUS: rd_data = status_q;
            PMI_ADDR_IRQ_MASK_A: rd_data = irq_mask_a_q;
            PMI_ADDR_IRQ_MASK_B: rd_data = irq_mask_b_q;
            PMI_ADDR_IRQ_CAUSE_A: rd_data = cause_a_q;
            PMI_ADDR_IRQ_CAUSE_B: rd_data = cause_b_q;
            PMI_ADDR_FAULT_MASK: rd_data = fault_mask_q;
            PMI_ADDR_MODE_CTRL: rd_data = mode_q & PMI_MODE_CTRL_USED;
            default: rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            status_q <= 8'h00;
            status_prev_q <= 8'h00;
        end else begin
            status_q <= supply_fault;
            status_prev_q <= status_q;
        end
    end

    // toggle of an unmasked status bit
    // independent of the interrupt line
    // Comparators are blanked while the system reset output is low
    assign fault_evt = system_reset_out_n &&
        |(toggled(status_q, status_prev_q) & ~fault_mask_q);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            supply_fault_evt <= 1'b0;
        end else begin
            supply_fault_evt <= fault_evt;
        end
    end

    // only power-on reset touches the registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fault_mask_q <= PMI_FAULT_MASK_RST;
        end else if (wr_fault_mask) begin
            fault_mask_q <= wr.data;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_mask_a_q <= PMI_IRQ_MASK_RST;
            irq_mask_b_q <= PMI_IRQ_MASK_RST;
        end else if (wr.valid) begin
            if (wr.addr == PMI_ADDR_IRQ_MASK_A) begin
                irq_mask_a_q <= wr.data;
            end
            if (wr.addr == PMI_ADDR_IRQ_MASK_B) begin
                irq_mask_b_q <= wr.data;
            end
        end
    end

    // Mode control register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mode_q <= PMI_MODE_CTRL_RST;
        end else begin
            if (wr_mode) begin
                mode_q <= wr.data & PMI_MODE_CTRL_USED;
            end else begin
                mode_q[PMI_MODE_SOFTRST_BIT] <= 1'b0;
                mode_q[PMI_MODE_SLEEP_BIT] <= 1'b0;
            end
            // defaults reload on supply fault wins over a host write
            if (fault_evt) begin
                mode_q[PMI_MODE_DFLT_N_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            soft_reset_req <= 1'b0;
            sleep_req <= 1'b0;
        end else begin
            soft_reset_req <= wr_mode && wr.data[PMI_MODE_SOFTRST_BIT];
            sleep_req <= wr_mode && wr.data[PMI_MODE_SLEEP_BIT];
        end
    end

    assign buck_standby_request = mode_q[PMI_MODE_STANDBY_BIT];
    assign led_boost_low_freq_osc = mode_q[PMI_MODE_LFOSC_BIT];

    // second group source levels; supply, charger and battery share one cause
    always_comb begin
        misc_now = 8'h00;
        misc_now[PMI_CB_ADC_BIT] = misc_status.adc_done;
        misc_now[PMI_CB_ANLG1_BIT] = misc_status.anlg1_open;
        misc_now[PMI_CB_THERM_BIT] = misc_status.thermal;
        misc_now[PMI_CB_ADC_HI_BIT] = misc_status.adc_hi;
        misc_now[PMI_CB_ADC_LO_BIT] = misc_status.adc_lo;
    end

    // Change detection; the history keeps running while an interrupt is pending,
    // so a change during that time is not replayed afterwards, except thermal, whose history bit holds the supply, charger and battery parity
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            misc_prev_q <= 8'h00;
            gpio_prev_q <= 2'h0;
        end else begin
            misc_prev_q <= {misc_now[7:4], misc_status.ext_supply ^ misc_status.charger ^
                            misc_status.battery, misc_now[2:0]} & 8'hCF;
            misc_prev_q[PMI_CB_CHG_BIT] <= misc_status.ext_supply ^ misc_status.charger ^
                                           misc_status.battery;
            gpio_prev_q <= gpio_in;
        end
    end

    // every monitored source feeds a cause bit
    // either edge on an input-configured pin
    always_comb begin
        chg_a = toggled(status_q, status_prev_q);
        chg_b = toggled(misc_now, misc_prev_q & 8'hCB);
        chg_b[PMI_CB_CHG_BIT] = (misc_status.ext_supply ^ misc_status.charger ^
                                 misc_status.battery) != misc_prev_q[PMI_CB_CHG_BIT];
        chg_b[PMI_CB_GPIO1_BIT] = gpio_is_input[0] && (gpio_in[0] != gpio_prev_q[0]);
        chg_b[PMI_CB_GPIO2_BIT] = gpio_is_input[1] && (gpio_in[1] != gpio_prev_q[1]);
    end

    // masked sources never reach the causes
    assign hit_a = chg_a & ~irq_mask_a_q;
    assign hit_b = chg_b & ~irq_mask_b_q;

    // capture only while the line is released and no cause stands
    // sources ignored while the system reset output is low
    assign irq_idle = !irq_low_q && (cause_a_q == 8'h00) && (cause_b_q == 8'h00) &&
                      system_reset_out_n;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cause_a_q <= PMI_CAUSE_RST;
            cause_b_q <= PMI_CAUSE_RST;
        end else if (irq_idle) begin
            // causes are set before the line falls
            cause_a_q <= hit_a;
            cause_b_q <= hit_b;
        end else if (wr.valid) begin
            // writing one leaves the bit as it is
            if (wr.addr == PMI_ADDR_IRQ_CAUSE_A) begin
                cause_a_q <= cause_a_q & wr.data;
            end
            if (wr.addr == PMI_ADDR_IRQ_CAUSE_B) begin
                cause_b_q <= cause_b_q & wr.data;
            end
        end
    end

    // line falls one cycle after the causes are set
    // line rises one cycle after the last cause is cleared
    // no timeout, only acknowledge or a low system reset output releases it
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_low_q <= 1'b0;
        end else begin
            irq_low_q <= (cause_a_q != 8'h00) || (cause_b_q != 8'h00);
        end
    end

    // line released while the system reset output is low
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_n_oe <= 1'b0;
        end else begin
            irq_n_oe <= system_reset_out_n &&
                        ((cause_a_q != 8'h00) || (cause_b_q != 8'h00));
        end
    end

    assign irq_n_out = 1'b0;

endmodule // pmi_mode_irq_ctrl

// ===== tb/pmi_host_model.sv
// Two-wire host model that reaches the register port of the block
`timescale 1ns/1ps
module pmi_host_model import pmi_pkg::*; (
    input wire logic clock, // System clock
    input wire logic sda, // Resolved data line level
    output logic scl, // Serial clock, idles high
    output logic sda_pull // High pulls the data line low
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // Four clocks a phase, above the three-clock minimum
    task automatic half();
        repeat (4) @(posedge clock);
        #1;
    endtask
    // Data moves one clock after the clock fall, so no false start or stop
    task automatic put_bit(input logic b, output logic r);
        @(posedge clock) #1;
        sda_pull = !b;
        half();
        scl = 1'b1;
        half();
        r = sda;
        scl = 1'b0;
    endtask
    task automatic start();
        @(posedge clock) #1;
        sda_pull = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_pull = 1'b1;
        half();
        scl = 1'b0;
    endtask
    task automatic stop();
        @(posedge clock) #1;
        sda_pull = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_pull = 1'b0;
        half();
    endtask
    // Ack bit always released: the slave acks writes, a read ends refused
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        logic a;
        for (int i = 7; i >= 0; i--) put_bit(tx[i], rx[i]);
        put_bit(1'b1, a);
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] rx;
        start();
        xfer({PMI_I2C_DEV_ADDR, 1'b0}, rx);
        xfer(a, rx);
        xfer(d, rx);
        stop();
    endtask
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        logic [7:0] rx;
        start();
        xfer({PMI_I2C_DEV_ADDR, 1'b0}, rx);
        xfer(a, rx);
        start();
        xfer({PMI_I2C_DEV_ADDR, 1'b1}, rx);
        xfer(8'hFF, d);
        stop();
    endtask
    task automatic abandon();
        logic r;
        start();
        for (int i = 0; i < 4; i++) put_bit(1'b1, r);
        stop();
    endtask
endmodule // pmi_host_model

// ===== tb/pmi_mode_irq_ctrl_properties.sv
// Concurrent checks on the ports of the mode and interrupt controller
`timescale 1ns/1ps
module pmi_mode_irq_ctrl_properties import pmi_pkg::*; (
    input wire logic clock, // System clock
    input wire logic rst, // Async reset
    input wire logic system_reset_out_n, // System reset level
    input wire logic scl, // Host serial clock
    input wire logic sda_out, // Data drive value
    input wire logic sda_oe, // Data pull enable
    input wire logic irq_n_out, // Interrupt drive value
    input wire logic irq_n_oe, // Interrupt pull enable
    input wire logic [7:0] supply_fault, // Supply fault levels
    input wire pmi_misc_s misc_status, // Other status levels
    input wire logic [1:0] gpio_in, // General pin levels
    input wire logic soft_reset_req, // Reset request pulse
    input wire logic sleep_req, // Sleep request pulse
    input wire logic supply_fault_evt // Supply fault pulse
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Window of two to five clocks covers both capture depths
    sequence s_supply_step;
        $past(supply_fault, 2) != $past(supply_fault, 5);
    endsequence
    sequence s_other_step;
        $past(gpio_in, 2) != $past(gpio_in, 5) || $past(misc_status, 2) != $past(misc_status, 5);
    endsequence
    a_soft_reset_pulse: assert property (soft_reset_req |=> !soft_reset_req)
        else $error("soft reset request longer than one clock");
    a_sleep_pulse: assert property (sleep_req |=> !sleep_req)
        else $error("sleep request longer than one clock");
    a_fault_cause: assert property (supply_fault_evt |-> s_supply_step)
        else $error("supply fault event without a supply change");
    a_fault_blank: assert property (!system_reset_out_n [*4] |-> !supply_fault_evt)
        else $error("supply fault event during system reset");
    a_irq_cause: assert property ($rose(irq_n_oe) |-> s_supply_step or s_other_step)
        else $error("interrupt raised without a source change");
    a_irq_held: assert property (irq_n_oe && system_reset_out_n && scl |=> irq_n_oe)
        else $error("interrupt released without a host write");
    a_irq_reset_off: assert property (!system_reset_out_n |=> !irq_n_oe)
        else $error("interrupt driven during system reset");
    a_port_quiet: assert property (!system_reset_out_n |=> !sda_oe)
        else $error("data line driven during system reset");
    a_open_drain: assert property (irq_n_out == 1'b0 && sda_out == 1'b0)
        else $error("open-drain drive value not low");
endmodule // pmi_mode_irq_ctrl_properties

bind pmi_mode_irq_ctrl pmi_mode_irq_ctrl_properties u_props (.clock, .rst, .system_reset_out_n,
    .scl, .sda_out, .sda_oe, .irq_n_out, .irq_n_oe, .supply_fault, .misc_status, .gpio_in,
    .soft_reset_req, .sleep_req, .supply_fault_evt);

// ===== tb/testbench.sv
// Self-checking bench for the mode and interrupt controller
`timescale 1ns/1ps
module testbench import pmi_pkg::*;;
    logic clock, rst, system_reset_out_n, scl, sda_in, sda_out, sda_oe, sda_pull;
    logic irq_n_out, irq_n_oe, soft_reset_req, sleep_req, supply_fault_evt;
    logic buck_standby_request, led_boost_low_freq_osc;
    logic [7:0] supply_fault;
    logic [1:0] gpio_in, gpio_is_input;
    pmi_misc_s misc_status;
    int miscompares = 0;
    int total_checks = 0;
    int n_soft = 0, n_sleep = 0, n_fault = 0;
    // Pull-up on the data line; either party may pull it low
    assign sda_in = !(sda_pull || sda_oe);
    pmi_mode_irq_ctrl i_pmi_mode_irq_ctrl (.clock, .rst, .system_reset_out_n, .scl, .sda_in,
        .sda_out, .sda_oe, .irq_n_out, .irq_n_oe, .supply_fault, .misc_status, .gpio_in,
        .gpio_is_input, .soft_reset_req, .sleep_req, .buck_standby_request,
        .led_boost_low_freq_osc, .supply_fault_evt);
    pmi_host_model host (.clock, .sda(sda_in), .scl, .sda_pull);
    always @(posedge clock) begin
        n_soft <= n_soft + int'(soft_reset_req);
        n_sleep <= n_sleep + int'(sleep_req);
        n_fault <= n_fault + int'(supply_fault_evt);
    end
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [7:0] v;
        host.reg_read(a, v);
        check(what, exp, v);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wait_irq(input logic exp);
        for (int i = 0; i < 12 && irq_n_oe !== exp; i++) tick(1);
        check("irq_n_oe", {7'h00, exp}, {7'h00, irq_n_oe});
    endtask
    task automatic t_regs();
        supply_fault = 8'h81;
        rd(PMI_ADDR_FAULT_MASK, PMI_FAULT_MASK_RST, "fault_mask");
        rd(PMI_ADDR_MODE_CTRL, PMI_MODE_CTRL_RST, "mode_ctrl");
        rd(PMI_ADDR_SUPPLY_STATUS, 8'h81, "supply_status");
        host.reg_write(PMI_ADDR_SUPPLY_STATUS, 8'h3C);
        rd(PMI_ADDR_SUPPLY_STATUS, 8'h81, "status_read_only");
        rd(8'h1F, 8'h00, "unmapped");
    endtask
    task automatic t_mode();
        host.reg_write(PMI_ADDR_FAULT_MASK, 8'h7F);
        host.reg_write(PMI_ADDR_MODE_CTRL, 8'hCB);
        check("soft_reset_req", 8'h01, 8'(n_soft));
        check("sleep_req", 8'h01, 8'(n_sleep));
        check("standby", 8'h01, {7'h00, buck_standby_request});
        check("low_freq_osc", 8'h01, {7'h00, led_boost_low_freq_osc});
        rd(PMI_ADDR_MODE_CTRL, 8'h8A, "mode_self_clear");
        rd(PMI_ADDR_FAULT_MASK, 8'h7F, "mask_kept");
    endtask
    task automatic t_fault();
        supply_fault[0] = 1'b0;
        tick(8);
        check("masked_fault", 8'h00, 8'(n_fault));
        supply_fault[7] = 1'b0;
        tick(8);
        check("unmasked_fault", 8'h01, 8'(n_fault));
        rd(PMI_ADDR_MODE_CTRL, 8'h88, "defaults_flag");
    endtask
    task automatic t_irq();
        host.reg_write(PMI_ADDR_IRQ_MASK_B, 8'h00);
        host.reg_write(PMI_ADDR_IRQ_MASK_A, 8'h7F);
        gpio_in[0] = 1'b1;
        wait_irq(1'b1);
        rd(PMI_ADDR_IRQ_CAUSE_B, 8'h10, "cause_b_gpio");
        gpio_in[1] = 1'b1;
        supply_fault[7] = 1'b1;
        tick(8);
        check("fault_while_low", 8'h02, 8'(n_fault));
        rd(PMI_ADDR_IRQ_CAUSE_B, 8'h10, "cause_b_latched");
        rd(PMI_ADDR_IRQ_CAUSE_A, 8'h00, "cause_a_latched");
        host.reg_write(PMI_ADDR_IRQ_CAUSE_B, 8'hFF);
        wait_irq(1'b1);
        host.abandon();
        wait_irq(1'b1);
        host.reg_write(PMI_ADDR_IRQ_CAUSE_B, 8'h00);
        wait_irq(1'b0);
        host.reg_write(PMI_ADDR_IRQ_MASK_B, 8'h08);
        misc_status.thermal = 1'b1;
        tick(8);
        check("masked_source", 8'h00, {7'h00, irq_n_oe});
        misc_status.charger = 1'b1;
        wait_irq(1'b1);
        rd(PMI_ADDR_IRQ_CAUSE_B, 8'h04, "cause_b_charger");
        host.reg_write(PMI_ADDR_IRQ_CAUSE_B, 8'h00);
        wait_irq(1'b0);
    endtask
    // Run ends with the system reset still low, so no re-arm is judged
    task automatic t_sysrst();
        gpio_in[0] = 1'b0;
        wait_irq(1'b1);
        system_reset_out_n = 1'b0;
        wait_irq(1'b0);
        gpio_in[1] = 1'b0;
        supply_fault[7] = 1'b0;
        tick(8);
        check("fault_in_reset", 8'h02, 8'(n_fault));
        check("irq_in_reset", 8'h00, {7'h00, irq_n_oe});
    endtask
    task automatic stop_test();
        if (miscompares == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        rst = 1'b1;
        system_reset_out_n = 1'b1;
        supply_fault = 8'h00;
        misc_status = '0;
        gpio_in = 2'b00;
        gpio_is_input = 2'b11;
        tick(20);
        rst = 1'b0;
        t_regs();
        t_mode();
        t_fault();
        t_irq();
        t_sysrst();
        stop_test();
    end
    initial begin
        #400us;
        miscompares++;
        stop_test();
    end
endmodule // testbench
